// File: lcc_burst_addr.sv
// Generator of the next CPU burst address in toggle or linear order.
`default_nettype none

module lcc_burst_addr
    import lcc_pkg::*;
(
    // Order and position
    input wire logic linear,
    input wire logic [31:0] start_addr,
    input wire logic [1:0] beat,
    // Address of this beat
    output logic [31:0] beat_addr
);

    // Toggle order XORs the beat into the dword index; linear order adds and wraps.
    always_comb begin
        beat_addr = start_addr;
        if (linear) begin
            beat_addr[3:2] = 2'(start_addr[3:2] + beat); // RULE1
        end else begin
            beat_addr[3:2] = start_addr[3:2] ^ beat; // RULE1
        end
    end

endmodule : lcc_burst_addr

`default_nettype wire

// File: lcc_decode.sv
// Decoder that turns the raw configuration word into timing and mode settings.
`default_nettype none

module lcc_decode
    import lcc_pkg::*;
(
    // Raw register
    input wire logic [15:0] cfg_word,
    // Decoded settings
    output lcc_pkg::lcc_cfg_t cfg
);

    always_comb begin
        cfg.linear = cfg_word[LCC_BURST_ORDER_BIT]; // RULE1
        cfg.wr_single = cfg_word[LCC_WRITE_FAST_BIT] ? LCC_WR_SINGLE_FAST
                                                      : LCC_WR_SINGLE_SLOW; // RULE2
        cfg.wr_burst = cfg_word[LCC_WRITE_FAST_BIT] ? LCC_WR_BURST_FAST
                                                     : LCC_WR_BURST_SLOW; // RULE2
        cfg.rd_next = cfg_word[LCC_BURST_SLOW_BIT] ? LCC_RD_NEXT_SLOW
                                                    : LCC_RD_NEXT_FAST; // RULE3
        cfg.leadoff = cfg_word[LCC_LEADOFF_FAST_BIT] ? LCC_LEADOFF_FAST
                                                      : LCC_LEADOFF_SLOW; // RULE4
        cfg.write_back = cfg_word[LCC_WRITE_BACK_BIT]; // RULE5
        cfg.size = cfg_word[LCC_SIZE_LSB +: 3];
        cfg.size_ok = (cfg.size >= LCC_SIZE_64K) && (cfg.size <= LCC_SIZE_1M); // RULE6
        cfg.interleave = cfg_word[LCC_INTERLEAVE_BIT]; // RULE7
        cfg.force_dirty = cfg_word[LCC_FORCE_DIRTY_BIT]; // RULE8
        cfg.tag7 = cfg_word[LCC_TAG7_BIT]; // RULE9
        cfg.always_hit = cfg_word[LCC_ALWAYS_HIT_BIT]; // RULE10
        cfg.enable = cfg_word[LCC_ENABLE_BIT]; // RULE11
    end

endmodule : lcc_decode

`default_nettype wire

// File: lcc_pkg.sv
// Package for the second-level cache configuration block: offsets, fields, timing counts.
//Operation
// RULE1 - Burst addresses follow interleaved order when bit 15 is 0 and linear order when it is 1.
// RULE2 - Cache single and burst writes take 3 and 2 clocks when bit 11 is 0, 2 and 1 when it is 1.
// RULE3 - Each later transfer of a cache burst read waits 1 clock when bit 10 is 0, 2 when it is 1.
// RULE4 - Single and burst read lead-off waits 3 clocks when bit 9 is 0, 2 when it is 1.
// RULE5 - The cache is write-through when bit 8 is 0 and write-back when it is 1.
// RULE6 - Size codes 001 to 101 mean 64 KB to 1 MB; every other code is reserved.
// RULE7 - The SRAM is one bank when bit 4 is 0 and two interleaved banks when it is 1.
// RULE8 - Dirty status comes from the dirty input when bit 3 is 0 and is always dirty when it is 1.
// RULE9 - Bit 2 at 0 gives an 8-bit tag with the shared pin as top tag bit; at 1 a 7-bit tag with that pin as dirty.
// RULE10 - Every lookup hits while bit 1 is 1; tags are compared while it is 0.
// RULE11 - The cache is used only while bit 0 is 1 and bypassed while it is 0.
// RULE12 - The configuration is a 16-bit read/write register that resets to all zeros.
// RULE13 - Software programs only defined size codes and sets size, tag width and interleave before enable; the bench writes all eight codes with enable set.
`default_nettype none

package lcc_pkg;

    localparam logic [11:0] LCC_CFG_OFFSET = 12'h000;
    localparam logic [11:0] LCC_STATUS_OFFSET = 12'h004;
    localparam logic [15:0] LCC_CFG_RESET = 16'h0000;

    localparam int LCC_BURST_ORDER_BIT = 15;
    localparam int LCC_WRITE_FAST_BIT = 11;
    localparam int LCC_BURST_SLOW_BIT = 10;
    localparam int LCC_LEADOFF_FAST_BIT = 9;
    localparam int LCC_WRITE_BACK_BIT = 8;
    localparam int LCC_SIZE_LSB = 5;
    localparam int LCC_INTERLEAVE_BIT = 4;
    localparam int LCC_FORCE_DIRTY_BIT = 3;
    localparam int LCC_TAG7_BIT = 2;
    localparam int LCC_ALWAYS_HIT_BIT = 1;
    localparam int LCC_ENABLE_BIT = 0;
    localparam logic [15:0] LCC_CFG_WMASK = 16'h8FFF;

    localparam logic [2:0] LCC_SIZE_64K = 3'h1;
    localparam logic [2:0] LCC_SIZE_1M = 3'h5;

    // Wait counts in CPU clocks.
    localparam logic [1:0] LCC_WR_SINGLE_SLOW = 2'h3;
    localparam logic [1:0] LCC_WR_SINGLE_FAST = 2'h2;
    localparam logic [1:0] LCC_WR_BURST_SLOW = 2'h2;
    localparam logic [1:0] LCC_WR_BURST_FAST = 2'h1;
    localparam logic [1:0] LCC_RD_NEXT_FAST = 2'h1;
    localparam logic [1:0] LCC_RD_NEXT_SLOW = 2'h2;
    localparam logic [1:0] LCC_LEADOFF_SLOW = 2'h3;
    localparam logic [1:0] LCC_LEADOFF_FAST = 2'h2;

    typedef enum logic [1:0] {
        LCC_IDLE = 2'b00,
        LCC_LEAD = 2'b01,
        LCC_DATA = 2'b11,
        LCC_NEXT = 2'b10
    } lcc_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic burst;
        logic [31:0] addr;
    } lcc_req_t;

    typedef struct packed {
        logic linear;
        logic [1:0] wr_single;
        logic [1:0] wr_burst;
        logic [1:0] rd_next;
        logic [1:0] leadoff;
        logic write_back;
        logic [2:0] size;
        logic size_ok;
        logic interleave;
        logic force_dirty;
        logic tag7;
        logic always_hit;
        logic enable;
    } lcc_cfg_t;

endpackage : lcc_pkg

`default_nettype wire

// File: lcc_sram_model.sv
// Behavioural tag SRAM and shared dirty pin on the far side of the cache controller.
`default_nettype none

module lcc_sram_model
    import lcc_pkg::*;
(
    // Line being looked up and the state of the stored line
    input wire logic [31:0] look_addr,
    input wire logic match,
    input wire logic dirty,
    input wire logic tag7,
    // Tag SRAM data and shared pin
    output logic [6:0] tag_ram_in,
    output logic tag_top_bit_input
);

    // Asynchronous SRAM answers at once. A miss flips one tag bit, so only a real compare hits.
    assign tag_ram_in = look_addr[25:19] ^ {6'h00, ~match};
    // The shared pin carries the top tag bit or the dirty flag, by tag width.
    assign tag_top_bit_input = tag7 ? dirty : look_addr[26];

endmodule : lcc_sram_model

`default_nettype wire

// File: lcc_top.sv
// Second-level cache configuration register with APB access and cache cycle timing.
//
// Added by the designer: the APB slave port and the placing of the registers.
`default_nettype none

module lcc_top
    import lcc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU cycle request, same clock
    input wire lcc_pkg::lcc_req_t cpu_req,
    // Cache pins
    input wire logic tag_top_bit_input,
    input wire logic [6:0] tag_ram_in,
    // Cycle results
    output logic cache_used,
    output logic cache_hit,
    output logic line_dirty,
    output logic cycle_ready,
    output logic cycle_done,
    output logic [31:0] burst_addr,
    output logic bank_sel,
    output logic write_back_mode
);

    logic [15:0] cfg_reg, cfg_next;
    lcc_cfg_t cfg;
    logic [1:0] pin_sync1_reg, pin_sync2_reg;
    logic [1:0] pin_sync1_next;
    logic [6:0] tag_sync1_reg, tag_sync2_reg;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;
    logic pready_reg, pready_next;
    lcc_state_t state_reg, state_next;
    logic [1:0] wait_reg, wait_next;
    logic [1:0] beat_reg, beat_next;
    logic [31:0] addr_reg, addr_next;
    logic write_reg, write_next, burst_reg, burst_next;
    logic [6:0] tag_hold_reg, tag_hold_next;
    logic used_reg, used_next, hit_reg, hit_next, dirty_reg, dirty_next;
    logic ready_reg, ready_next, done_reg, done_next;
    logic [31:0] beat_addr;
    logic [31:0] baddr_reg;
    logic bank_reg, wb_reg;

    lcc_decode u_decode (
        .cfg_word(cfg_reg),
        .cfg(cfg)
    );

    lcc_burst_addr u_burst (
        .linear(cfg.linear),
        .start_addr(addr_reg),
        .beat(beat_reg),
        .beat_addr(beat_addr)
    );

    function automatic logic [1:0] first_wait(input logic wr, input logic [1:0] lead,
                                              input logic [1:0] wsingle, input logic [1:0] wburst,
                                              input logic bst);
        if (wr) begin
            first_wait = bst ? wburst : wsingle;
        end else begin
            first_wait = lead;
        end
    endfunction : first_wait

    // APB access: one wait-free access phase, answer registered on the setup cycle.
    always_comb begin
        cfg_next = cfg_reg;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        pready_next = 1'b0;
        if (psel && !penable) begin
            pready_next = 1'b1;
            prdata_next = 32'h0000_0000;
            if (paddr == LCC_CFG_OFFSET) begin
                prdata_next = {16'h0000, cfg_reg};
            end else if (paddr == LCC_STATUS_OFFSET) begin
                prdata_next = {24'h000000, cfg.size_ok, 2'b00, state_reg, used_reg,
                               hit_reg, dirty_reg};
                pslverr_next = pwrite;
            end else begin
                pslverr_next = 1'b1;
            end
        end
        // The write lands at the access edge, where the master samples pready high.
        if (psel && penable && pready_reg && pwrite && paddr == LCC_CFG_OFFSET) begin
            // Reserved bits 14:12 stay zero.
            cfg_next = pwdata[15:0] & LCC_CFG_WMASK; // RULE12
        end
    end

    // The register changes at the access-phase edge only, as the master expects.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= LCC_CFG_RESET; // RULE12
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            pready_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
            pready_reg <= pready_next;
        end
    end

    // The shared pin and tag pins come from off-chip SRAM and are synchronised first.
    always_comb begin
        pin_sync1_next = {tag_top_bit_input, 1'b0};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync1_reg <= 2'b00;
            pin_sync2_reg <= 2'b00;
            tag_sync1_reg <= 7'h00;
            tag_sync2_reg <= 7'h00;
        end else begin
            pin_sync1_reg <= pin_sync1_next;
            pin_sync2_reg <= pin_sync1_reg;
            tag_sync1_reg <= tag_ram_in;
            tag_sync2_reg <= tag_sync1_reg;
        end
    end

    // Cycle engine: lead-off or first write wait, data strobe, then per-beat wait.
    always_comb begin
        state_next = state_reg;
        wait_next = wait_reg;
        beat_next = beat_reg;
        addr_next = addr_reg;
        write_next = write_reg;
        burst_next = burst_reg;
        tag_hold_next = tag_hold_reg;
        used_next = used_reg;
        hit_next = hit_reg;
        dirty_next = dirty_reg;
        ready_next = 1'b0;
        done_next = 1'b0;
        case (state_reg)
            LCC_IDLE: begin
                if (cpu_req.valid) begin
                    addr_next = cpu_req.addr;
                    write_next = cpu_req.write;
                    burst_next = cpu_req.burst;
                    beat_next = 2'h0;
                    used_next = cfg.enable && cfg.size_ok; // RULE11 RULE6
                    tag_hold_next = cpu_req.addr[25:19];
                    wait_next = first_wait(cpu_req.write, cfg.leadoff, cfg.wr_single,
                                           cfg.wr_burst, cpu_req.burst); // RULE2 RULE4
                    state_next = LCC_LEAD;
                end
            end
            LCC_LEAD: begin
                if (used_reg) begin
                    if (cfg.always_hit) begin
                        hit_next = 1'b1; // RULE10
                    end else if (cfg.tag7) begin
                        hit_next = (tag_sync2_reg == tag_hold_reg); // RULE9
                    end else begin
                        hit_next = (tag_sync2_reg == tag_hold_reg) &&
                                   (pin_sync2_reg[1] == addr_reg[26]); // RULE9
                    end
                end else begin
                    hit_next = 1'b0; // RULE11
                end
                if (cfg.force_dirty) begin
                    dirty_next = used_reg; // RULE8
                end else begin
                    dirty_next = used_reg && cfg.tag7 && pin_sync2_reg[1]; // RULE8 RULE9
                end
                if (wait_reg <= 2'h1) begin
                    state_next = LCC_DATA;
                end else begin
                    wait_next = 2'(wait_reg - 2'h1);
                end
            end
            LCC_DATA: begin
                ready_next = 1'b1;
                if (!burst_reg || beat_reg == 2'h3) begin
                    done_next = 1'b1;
                    state_next = LCC_IDLE;
                end else begin
                    beat_next = 2'(beat_reg + 2'h1);
                    wait_next = write_reg ? cfg.wr_burst : cfg.rd_next; // RULE2 RULE3
                    state_next = (wait_next == 2'h1) ? LCC_DATA : LCC_NEXT;
                end
            end
            LCC_NEXT: begin
                if (wait_reg <= 2'h2) begin
                    state_next = LCC_DATA;
                end else begin
                    wait_next = 2'(wait_reg - 2'h1);
                end
            end
            default: begin
                state_next = LCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= LCC_IDLE;
            wait_reg <= 2'h0;
            beat_reg <= 2'h0;
            addr_reg <= 32'h0000_0000;
            write_reg <= 1'b0;
            burst_reg <= 1'b0;
            tag_hold_reg <= 7'h00;
            used_reg <= 1'b0;
            hit_reg <= 1'b0;
            dirty_reg <= 1'b0;
            ready_reg <= 1'b0;
            done_reg <= 1'b0;
            baddr_reg <= 32'h0000_0000;
            bank_reg <= 1'b0;
            wb_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            beat_reg <= beat_next;
            addr_reg <= addr_next;
            write_reg <= write_next;
            burst_reg <= burst_next;
            tag_hold_reg <= tag_hold_next;
            used_reg <= used_next;
            hit_reg <= hit_next;
            dirty_reg <= dirty_next;
            ready_reg <= ready_next;
            done_reg <= done_next;
            baddr_reg <= beat_addr;
            bank_reg <= cfg.interleave & beat_addr[2]; // RULE7
            wb_reg <= cfg.write_back; // RULE5
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign cache_used = used_reg;
    assign cache_hit = hit_reg;
    assign line_dirty = dirty_reg;
    assign cycle_ready = ready_reg;
    assign cycle_done = done_reg;
    assign burst_addr = baddr_reg;
    assign bank_sel = bank_reg;
    assign write_back_mode = wb_reg;

    AST_RESET_ZERO: assert property (@(posedge pclk) $rose(presetn) |-> cfg_reg == 16'h0000)
        else $error("config not zero after reset"); // RULE12
    AST_DISABLED_MISS: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == LCC_LEAD && !used_reg) |=> !hit_reg)
        else $error("hit while cache bypassed"); // RULE11
    AST_ALWAYS_HIT: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == LCC_LEAD && used_reg && cfg.always_hit) |=> hit_reg)
        else $error("test mode did not hit"); // RULE10
    AST_FORCE_DIRTY: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == LCC_LEAD && used_reg && cfg.force_dirty) |=> dirty_reg)
        else $error("forced dirty not seen"); // RULE8
    AST_WB_MODE: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 write_back_mode == $past(cfg_reg[LCC_WRITE_BACK_BIT]))
        else $error("policy output wrong"); // RULE5
    AST_BANK_SINGLE: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg.interleave |=> !bank_sel)
        else $error("bank select in single-bank mode"); // RULE7
    AST_LEAD_SLOW: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == LCC_IDLE && cpu_req.valid && !cpu_req.write && cfg.leadoff[0]
         && !psel) |=> ##4 cycle_ready)
        else $error("lead-off not three clocks"); // RULE4
    AST_BURST_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg.linear |=> burst_addr[3:2] == ($past(addr_reg[3:2]) ^ $past(beat_reg)))
        else $error("toggle order wrong"); // RULE1
    AST_SIZE_USE: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == LCC_IDLE && cpu_req.valid && !cfg.size_ok) |=> !cache_used)
        else $error("reserved size used"); // RULE6

endmodule : lcc_top

`default_nettype wire

// File: tb.sv
// Self-checking bench for the cache configuration register and cache cycle timing.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lcc_pkg::*;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, burst_addr, look_addr, rd, w, a;
    lcc_req_t cpu_req;
    logic [6:0] tag_ram_in;
    logic tag_top_bit_input, cache_used, cache_hit, line_dirty, cycle_ready, cycle_done;
    logic bank_sel, write_back_mode, match, dirty, err;
    logic [15:0] cfg_m;
    int failures = 0;
    int num_checks = 0;
    int seed = 32'h8DC99164;
    int i, j;

    lcc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_req(cpu_req), .tag_top_bit_input(tag_top_bit_input),
        .tag_ram_in(tag_ram_in), .cache_used(cache_used), .cache_hit(cache_hit),
        .line_dirty(line_dirty), .cycle_ready(cycle_ready), .cycle_done(cycle_done),
        .burst_addr(burst_addr), .bank_sel(bank_sel), .write_back_mode(write_back_mode));

    lcc_sram_model i_sram (.look_addr(look_addr), .match(match), .dirty(dirty),
        .tag7(cfg_m[2]), .tag_ram_in(tag_ram_in), .tag_top_bit_input(tag_top_bit_input));

    always #5 pclk = ~pclk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic conclude;
        $display("Checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 1, pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (wr && err === 1'b0 && ad == LCC_CFG_OFFSET) begin
            cfg_m = d[15:0] & LCC_CFG_WMASK;
        end
    endtask : apb

    // One CPU cycle; beat times and results come from the bench's own model of the settings.
    task automatic cpu(input logic wr, input logic bst, input logic [31:0] ad);
        int pos[$];
        int k, b, nb, first, step;
        logic [31:0] ea;
        logic used;
        if (wr) begin
            first = bst ? (cfg_m[11] ? 1 : 2) : (cfg_m[11] ? 2 : 3);
            step = first;
        end else begin
            first = cfg_m[9] ? 2 : 3;
            step = cfg_m[10] ? 2 : 1;
        end
        nb = bst ? 4 : 1;
        for (b = 0; b < nb; b++) begin
            // The wait cycles are followed by the data cycle that raises the strobe.
            pos.push_back(first + 1 + b * step);
        end
        used = cfg_m[0] && cfg_m[7:5] >= 3'h1 && cfg_m[7:5] <= 3'h5;
        @(posedge pclk);
        look_addr <= ad;
        match <= 1'($random(seed));
        dirty <= 1'($random(seed));
        // The tag pins pass a two-flop synchroniser, so they settle before the request.
        repeat (4) @(posedge pclk);
        cpu_req <= '{1'b1, wr, bst, ad};
        @(posedge pclk);
        cpu_req.valid <= 1'b0;
        b = 0;
        for (k = 1; k <= 30 && b < nb; k++) begin
            @(posedge pclk);
            #1;
            chk("cycle_ready", 32'(pos[b] == k), cycle_ready);
            if (pos[b] == k) begin
                ea = ad;
                ea[3:2] = cfg_m[15] ? ad[3:2] + b[1:0] : ad[3:2] ^ b[1:0];
                chk("burst_addr", ea, burst_addr);
                chk("bank_sel", cfg_m[4] & ea[2], bank_sel);
                chk("cycle_done", 32'(b == nb - 1), cycle_done);
                chk("cache_used", used, cache_used);
                chk("write_back_mode", cfg_m[8], write_back_mode);
                if (used) begin
                    chk("cache_hit", cfg_m[1] | match, cache_hit);
                    chk("line_dirty", cfg_m[3] | (cfg_m[2] & dirty), line_dirty);
                end
                b++;
            end
        end
        chk("beats", nb, b);
    endtask : cpu

    initial begin
        #500000;
        failures++;
        $display("ERROR watchdog expected finish seen hang");
        conclude();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        cpu_req = '0;
        look_addr = 32'h00000000;
        match = 1'b0;
        dirty = 1'b0;
        cfg_m = 16'h0000;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, LCC_CFG_OFFSET, 32'h0);
        chk("cfg_reset", {16'h0000, LCC_CFG_RESET}, rd);
        apb(1'b1, LCC_CFG_OFFSET, 32'hFFFFFFFF);
        apb(1'b0, LCC_CFG_OFFSET, 32'h0);
        chk("cfg_readback", {16'h0000, cfg_m}, rd);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped_err", 1, err);
        chk("unmapped_data", 0, rd);
        apb(1'b1, 12'h008, 32'h00000000);
        chk("unmapped_write_err", 1, err);
        apb(1'b1, LCC_STATUS_OFFSET, 32'h00000000);
        chk("status_write_err", 1, err);
        apb(1'b0, LCC_CFG_OFFSET, 32'h0);
        chk("cfg_kept", {16'h0000, cfg_m}, rd);
        // Every size code, random timing and mode bits, all four cycle kinds each.
        for (i = 0; i < 16; i++) begin
            w = 32'($random(seed));
            w[7:5] = i[2:0];
            w[0] = (i < 8) ? 1'b1 : w[0];
            apb(1'b1, LCC_CFG_OFFSET, w);
            chk("cfg_write_err", 0, err);
            for (j = 0; j < 4; j++) begin
                a = 32'($random(seed)) & 32'hFFFFFFFC;
                cpu(j[1], j[0], a);
            end
        end
        conclude();
    end

endmodule : tb

`default_nettype wire
